// File: ext_source_model.sv
// Purpose: far-side model of the first external interrupt pin
// Assumes: source runs from the system clock
// Notes: the request is a level that the source owns and clears
`timescale 1ns/1ps
module ext_source_model
(
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // control from the bench and the core
   input wire logic fire,
   input wire logic clear,
   input wire logic service,
   // pin
   output logic line
);
   // hold until serviced or cleared
   // a resume does not drop the line, so the flag stays set
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         line <= 1'b0;
      else if (fire)
         line <= 1'b1;
      else if (service || clear)
         line <= 1'b0;
   end
endmodule

// File: irq_priority_pick.sv
// Purpose: pick the highest-level pending request among all sources
// Assumes: requests already gated by enable and eligibility
// Notes: equal levels resolve to the lowest source index
`timescale 1ns/1ps
module irq_priority_pick
(
   // requests and their levels
   input wire logic [standby_pkg::NUM_SRC-1:0] req,
   input wire logic [standby_pkg::NUM_SRC-1:0][2:0] level,
   // winner
   output standby_pkg::irq_pick_s pick
);

   // scanning downward with >= lets the lower index win a tie
   always_comb
   begin
      pick = '0;
      for (int i = standby_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (req[i] && (!pick.valid || level[i] >= pick.level))
         begin
            pick.valid = 1'b1;
            pick.level = level[i];
            pick.index = 6'(i);
         end
      end
   end

endmodule

// File: standby_pkg.sv
// Purpose: shared constants and types for the standby and wake-up controller
// Assumes: 25 MHz system clock, one clock domain
// Notes: source order is cpu (0-8), external pins (9-17), internal peripherals (18-47)
package standby_pkg;

   // source map
   localparam int NUM_SRC = 48;
   localparam int NUM_CPU_SRC = 9;
   localparam int NUM_EXT = 9;
   localparam int NUM_PERIPH = 30;
   localparam int NUM_MASKABLE = 39;
   localparam int EXT_BASE = 9;
   localparam int PERIPH_BASE = 18;
   localparam int EXT_ZERO_IDX = 9;
   localparam int RTC_IDX = 18;
   localparam int NUM_TIMER_IDLE = 8;

   // halt mode encodings
   localparam logic [1:0] MODE_PERIPH_IDLE = 2'h3;
   localparam logic [1:0] MODE_OSC_IDLE = 2'h2;
   localparam logic [1:0] MODE_FULL_STOP = 2'h1;
   localparam logic [1:0] MODE_NONE = 2'h0;

   // warm-up select encodings and lengths in oscillator cycles
   localparam logic [1:0] WUP_SEL_01 = 2'h1;
   localparam logic [1:0] WUP_SEL_10 = 2'h2;
   localparam logic [1:0] WUP_SEL_11 = 2'h3;
   localparam int WARMUP_W = 19;
   localparam logic [18:0] WARMUP_LEN_01 = 19'h00100;
   localparam logic [18:0] WARMUP_LEN_10 = 19'h04000;
   localparam logic [18:0] WARMUP_LEN_11 = 19'h10000;
   localparam logic [18:0] WARMUP_LEN_00 = 19'h40000;

   // priority levels
   localparam logic [2:0] LEVEL_TOP = 3'h7;
   localparam logic [2:0] LEVEL_OFF = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h7;

   // low-frequency oscillator tick derived from the system clock
   localparam int CLK_HZ = 25000000;
   localparam int LOW_OSC_HZ = 32768;
   localparam int LOW_OSC_DIV = CLK_HZ / LOW_OSC_HZ;
   localparam int LOW_DIV_W = 10;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_HALT = 2'h1,
      ST_WARM = 2'h3,
      ST_RESUME = 2'h2
   } standby_state_e;

   typedef struct packed {
      logic [1:0] halt_mode_select;
      logic [1:0] warmup_select;
      logic resume_low_osc;
      logic stop_drive;
   } standby_cfg_s;

   typedef struct packed {
      logic valid;
      logic [2:0] level;
      logic [5:0] index;
   } irq_pick_s;

endpackage

// File: standby_wakeup_control.sv
// Purpose: standby entry, wake-up, warm-up timing and interrupt level forwarding
// Assumes: core pulses HALT_REQ, EI_STROBE, DI_STROBE for one cycle
// Notes: oscillator gating is expressed as enable outputs, not as clock muxing
//
// Function
// - peripheral idle stops the cpu; only selected peripherals keep running
// - oscillator idle gates system clock; oscillator and rtc keep running
// - wake request levels are watched every cycle while halted, not latched; exit happens on the clock edge
// - full stop halts every circuit including the oscillator
// - system clock stays off until warm-up after full stop has elapsed
// - warm-up select 01/10/11/00 gives 2^8/2^14/2^16/2^18 oscillator cycles
// - resume select bit picks high (0) or low (1) oscillator after stop
// - wake from full stop completes only after the warm-up interval
// - wake at or above the mask leaves halt and services the interrupt
// - permitted wake below the mask resumes after halt without service
// - non-maskable sources sit at level 7 and are never masked
// - in full stop the stop-drive bit decides whether outputs keep driving
// - 48 sources: 9 cpu, 9 external, 30 internal, fixed index each
// - maskable levels are programmable; non-maskable are fixed at 7
// - only the highest pending level is forwarded to the cpu
// - cpu accepts when forwarded level reaches the three-bit mask
// - enable instruction loads the mask, effective right after it
// - disable instruction sets the mask to 7, blocking all maskable levels
// - reset releases any standby state and reinitialises all settings
// - external zero and rtc wake below the mask; their request stays set
// - reset sets the interrupt mask to 111
`timescale 1ns/1ps
module standby_wakeup_control
#(
   parameter logic [18:0] WARMUP_LEN_01 = standby_pkg::WARMUP_LEN_01,
   parameter logic [18:0] WARMUP_LEN_10 = standby_pkg::WARMUP_LEN_10,
   parameter logic [18:0] WARMUP_LEN_11 = standby_pkg::WARMUP_LEN_11,
   parameter logic [18:0] WARMUP_LEN_00 = standby_pkg::WARMUP_LEN_00
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // core requests
   input wire logic HALT_REQ,
   input wire logic EI_STROBE,
   input wire logic [2:0] EI_OPERAND,
   input wire logic DI_STROBE,
   // configuration
   input standby_pkg::standby_cfg_s STANDBY_CFG,
   input wire logic [standby_pkg::NUM_PERIPH-1:0] PERIPH_IDLE_EN,
   input wire logic [standby_pkg::NUM_TIMER_IDLE-1:0] TIMER_IDLE_EN,
   // interrupt sources
   input wire logic [standby_pkg::NUM_CPU_SRC-1:0] CPU_IRQ,
   input wire logic [standby_pkg::NUM_EXT-1:0] EXT_IRQ,
   input wire logic [standby_pkg::NUM_PERIPH-1:0] PERIPH_IRQ,
   input wire logic [standby_pkg::NUM_MASKABLE-1:0][2:0] MASKABLE_LEVEL,
   // clock and power control
   output logic CPU_RUN,
   output logic SYSCLK_EN,
   output logic OSC_EN,
   output logic LOW_CLK_SEL,
   output logic WARMUP_BUSY,
   output logic [standby_pkg::NUM_PERIPH-1:0] PERIPH_RUN,
   // pins in full stop
   output logic PIN_OUT_KEEP,
   output logic PIN_IN_EN,
   // interrupt path to the core
   output logic [2:0] INTERRUPT_MASK_LEVEL,
   output standby_pkg::irq_pick_s IRQ_FWD,
   output logic IRQ_ACCEPT,
   output logic WAKE_SERVICE,
   output logic WAKE_RESUME
);

   localparam int NS = standby_pkg::NUM_SRC;
   localparam logic [standby_pkg::NUM_PERIPH-1:0] RTC_ONLY = 30'h00000001;

   standby_pkg::standby_state_e state;
   standby_pkg::standby_state_e next_state;
   logic [1:0] halt_mode;
   logic [1:0] next_mode;
   logic svc_wake;
   logic [standby_pkg::NUM_EXT-1:0] ext_meta;
   logic [standby_pkg::NUM_EXT-1:0] ext_sync;
   logic [NS-1:0] req_raw;
   logic [NS-1:0] req_eff;
   logic [NS-1:0] elig;
   logic [NS-1:0][2:0] level;
   standby_pkg::irq_pick_s pick;
   logic meets;
   logic low_wake;
   logic wake;
   logic [standby_pkg::WARMUP_W-1:0] warm_cnt;
   logic [standby_pkg::WARMUP_W-1:0] warm_target;
   logic [standby_pkg::LOW_DIV_W-1:0] div_cnt;
   logic tick;
   logic warm_done;
   logic in_stop;

   // external pins cross in through two flops
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ext_meta <= '0;
         ext_sync <= '0;
      end
      else
      begin
         ext_meta <= EXT_IRQ;
         ext_sync <= ext_meta;
      end
   end

   assign req_raw = {PERIPH_IRQ, ext_sync, CPU_IRQ};

   // per-source level, enable and wake eligibility
   for (genvar i = 0; i < NS; i++)
   begin : g_src
      logic peripheral_selective_idle_ok;
      if (i < standby_pkg::EXT_BASE)
      begin : g_cpu
         assign level[i] = standby_pkg::LEVEL_TOP;
         assign req_eff[i] = req_raw[i];
         assign peripheral_selective_idle_ok = 1'b1;
      end
      else
      begin : g_mask
         assign level[i] = MASKABLE_LEVEL[i - standby_pkg::EXT_BASE];
         assign req_eff[i] = req_raw[i] && level[i] != standby_pkg::LEVEL_OFF
            && level[i] != standby_pkg::LEVEL_TOP;
         if (i == standby_pkg::EXT_ZERO_IDX)
         begin : g_ext0
            assign peripheral_selective_idle_ok = 1'b1;
         end
         else if (i < standby_pkg::PERIPH_BASE)
         begin : g_ext
            assign peripheral_selective_idle_ok = TIMER_IDLE_EN[i - standby_pkg::EXT_ZERO_IDX - 1];
         end
         else
         begin : g_per
            assign peripheral_selective_idle_ok = PERIPH_IDLE_EN[i - standby_pkg::PERIPH_BASE];
         end
      end
      always_comb
      begin
         if (state == standby_pkg::ST_RUN)
            elig[i] = 1'b1;
         else if (halt_mode == standby_pkg::MODE_PERIPH_IDLE)
            elig[i] = peripheral_selective_idle_ok;
         else if (halt_mode == standby_pkg::MODE_OSC_IDLE)
            elig[i] = i == standby_pkg::EXT_ZERO_IDX || i == standby_pkg::RTC_IDX;
         else if (halt_mode == standby_pkg::MODE_FULL_STOP)
            elig[i] = i == standby_pkg::EXT_ZERO_IDX;
         else
            elig[i] = 1'b0;
      end
   end

   irq_priority_pick u_pick
   (
      .req(req_eff & elig),
      .level(level),
      .pick(pick)
   );

   assign meets = pick.valid && pick.level >= INTERRUPT_MASK_LEVEL;
   // external zero and rtc wake regardless of mask
   assign low_wake = (req_eff[standby_pkg::EXT_ZERO_IDX] && elig[standby_pkg::EXT_ZERO_IDX])
      || (req_eff[standby_pkg::RTC_IDX] && elig[standby_pkg::RTC_IDX]);
   // request level is watched every cycle; exit waits for the edge
   assign wake = meets || low_wake;

   always_comb
   begin
      if (STANDBY_CFG.warmup_select == standby_pkg::WUP_SEL_01)
         warm_target = WARMUP_LEN_01;
      else if (STANDBY_CFG.warmup_select == standby_pkg::WUP_SEL_10)
         warm_target = WARMUP_LEN_10;
      else if (STANDBY_CFG.warmup_select == standby_pkg::WUP_SEL_11)
         warm_target = WARMUP_LEN_11;
      else
         warm_target = WARMUP_LEN_00;
   end

   // low oscillator cycles are a divided enable; high runs at clock rate
   assign tick = !LOW_CLK_SEL || div_cnt == 10'(standby_pkg::LOW_OSC_DIV - 1);
   assign warm_done = tick && warm_cnt == warm_target - 19'h00001;

   always_comb
   begin
      next_state = state;
      next_mode = halt_mode;
      case (state)
         standby_pkg::ST_RUN:
         begin
            if (HALT_REQ && STANDBY_CFG.halt_mode_select != standby_pkg::MODE_NONE)
            begin
               next_state = standby_pkg::ST_HALT;
               next_mode = STANDBY_CFG.halt_mode_select;
            end
         end
         standby_pkg::ST_HALT:
         begin
            if (wake && halt_mode == standby_pkg::MODE_FULL_STOP)
               next_state = standby_pkg::ST_WARM;
            else if (wake)
               next_state = standby_pkg::ST_RESUME;
         end
         standby_pkg::ST_WARM:
         begin
            if (warm_done)
               next_state = standby_pkg::ST_RESUME;
         end
         default:
         begin
            next_state = standby_pkg::ST_RUN;
            next_mode = standby_pkg::MODE_NONE;
         end
      endcase
   end

   // reset returns to run with all settings cleared
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state <= standby_pkg::ST_RUN;
         halt_mode <= standby_pkg::MODE_NONE;
      end
      else
      begin
         state <= next_state;
         halt_mode <= next_mode;
      end
   end

   // service decision taken at wake; resume when below mask
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         svc_wake <= 1'b0;
      else if (state == standby_pkg::ST_HALT && wake)
         svc_wake <= meets;
   end

   // resume clock chosen at stop wake
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         LOW_CLK_SEL <= 1'b0;
      else if (state == standby_pkg::ST_HALT && wake
               && halt_mode == standby_pkg::MODE_FULL_STOP)
         LOW_CLK_SEL <= STANDBY_CFG.resume_low_osc;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         warm_cnt <= '0;
         div_cnt <= '0;
      end
      else if (state != standby_pkg::ST_WARM)
      begin
         warm_cnt <= '0;
         div_cnt <= '0;
      end
      else
      begin
         div_cnt <= tick ? '0 : div_cnt + 10'h001;
         if (tick)
            warm_cnt <= warm_cnt + 19'h00001;
      end
   end

   // mask loads at once; disable forces 7; reset value
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         INTERRUPT_MASK_LEVEL <= standby_pkg::MASK_RESET;
      else if (DI_STROBE)
         INTERRUPT_MASK_LEVEL <= standby_pkg::LEVEL_TOP;
      else if (EI_STROBE)
         INTERRUPT_MASK_LEVEL <= EI_OPERAND;
   end

   assign in_stop = next_mode == standby_pkg::MODE_FULL_STOP
      && (next_state == standby_pkg::ST_HALT || next_state == standby_pkg::ST_WARM);

   // outputs follow the next state so they line up with state itself
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         CPU_RUN <= 1'b1;
         SYSCLK_EN <= 1'b1;
         OSC_EN <= 1'b1;
         WARMUP_BUSY <= 1'b0;
         PERIPH_RUN <= '1;
         PIN_OUT_KEEP <= 1'b1;
         PIN_IN_EN <= 1'b1;
      end
      else
      begin
         CPU_RUN <= next_state == standby_pkg::ST_RUN;
         WARMUP_BUSY <= next_state == standby_pkg::ST_WARM;
         // oscillator off in full stop; clock off through warm-up
         OSC_EN <= !(in_stop && next_state == standby_pkg::ST_HALT);
         PIN_OUT_KEEP <= !in_stop || STANDBY_CFG.stop_drive;
         PIN_IN_EN <= !in_stop;
         if (next_state == standby_pkg::ST_RUN || next_state == standby_pkg::ST_RESUME)
         begin
            SYSCLK_EN <= 1'b1;
            PERIPH_RUN <= '1;
         end
         else if (next_state == standby_pkg::ST_HALT
                  && next_mode == standby_pkg::MODE_PERIPH_IDLE)
         begin
            SYSCLK_EN <= 1'b1;
            PERIPH_RUN <= PERIPH_IDLE_EN;
         end
         else if (next_state == standby_pkg::ST_HALT
                  && next_mode == standby_pkg::MODE_OSC_IDLE)
         begin
            SYSCLK_EN <= 1'b0;
            PERIPH_RUN <= RTC_ONLY;
         end
         else
         begin
            SYSCLK_EN <= 1'b0;
            PERIPH_RUN <= '0;
         end
      end
   end

   // request flags are owned by the sources, so a resumed wake leaves them set
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         IRQ_FWD <= '0;
         IRQ_ACCEPT <= 1'b0;
         WAKE_SERVICE <= 1'b0;
         WAKE_RESUME <= 1'b0;
      end
      else
      begin
         IRQ_FWD <= (state == standby_pkg::ST_RUN) ? pick : '0;
         IRQ_ACCEPT <= state == standby_pkg::ST_RUN && next_state == standby_pkg::ST_RUN
            && meets;
         WAKE_SERVICE <= state == standby_pkg::ST_RESUME && svc_wake;
         WAKE_RESUME <= state == standby_pkg::ST_RESUME && !svc_wake;
      end
   end

   chk_disable_sets_seven: assert property (
      @(posedge CLK) disable iff (!NRST)
      DI_STROBE |=> INTERRUPT_MASK_LEVEL == 3'h7)
      else $error("mask not 7 after disable");

   chk_enable_loads_mask: assert property (
      @(posedge CLK) disable iff (!NRST)
      EI_STROBE && !DI_STROBE |=> INTERRUPT_MASK_LEVEL == $past(EI_OPERAND))
      else $error("mask not loaded by enable");

   chk_warmup_clock_off: assert property (
      @(posedge CLK) disable iff (!NRST)
      WARMUP_BUSY |-> !SYSCLK_EN && !CPU_RUN && OSC_EN)
      else $error("system clock running during warm-up");

   chk_stop_all_off: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_HALT && halt_mode == standby_pkg::MODE_FULL_STOP
      |-> !OSC_EN && !SYSCLK_EN && PERIPH_RUN == '0)
      else $error("circuit left running in full stop");

   chk_osc_idle_rtc: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_HALT && halt_mode == standby_pkg::MODE_OSC_IDLE
      |-> !SYSCLK_EN && OSC_EN && PERIPH_RUN == RTC_ONLY)
      else $error("oscillator idle gating wrong");

   chk_periph_idle_sel: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_HALT && $past(state) == standby_pkg::ST_HALT
      && halt_mode == standby_pkg::MODE_PERIPH_IDLE
      |-> !CPU_RUN && PERIPH_RUN == $past(PERIPH_IDLE_EN))
      else $error("peripheral idle selection wrong");

   chk_stop_pin_drive: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_HALT && halt_mode == standby_pkg::MODE_FULL_STOP
      |-> !PIN_IN_EN && PIN_OUT_KEEP == $past(STANDBY_CFG.stop_drive))
      else $error("pin state in full stop wrong");

   chk_warmup_length: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_WARM && next_state == standby_pkg::ST_RESUME
      |-> warm_cnt == warm_target - 19'h00001)
      else $error("warm-up ended at wrong count");

   chk_wake_service: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_HALT && meets && halt_mode != standby_pkg::MODE_FULL_STOP
      |=> state == standby_pkg::ST_RESUME ##1 WAKE_SERVICE && !WAKE_RESUME)
      else $error("enabled wake not serviced");

   chk_wake_resume: assert property (
      @(posedge CLK) disable iff (!NRST)
      state == standby_pkg::ST_HALT && !meets && low_wake
      && halt_mode != standby_pkg::MODE_FULL_STOP
      |=> ##1 WAKE_RESUME && !WAKE_SERVICE)
      else $error("masked wake did not plain resume");

   chk_accept_level: assert property (
      @(posedge CLK) disable iff (!NRST)
      IRQ_ACCEPT |-> IRQ_FWD.valid && IRQ_FWD.level >= $past(INTERRUPT_MASK_LEVEL))
      else $error("accepted below mask");

endmodule

// File: standby_wakeup_control_tb.sv
// Purpose: self-checking bench for standby entry, wake-up and masking
// Assumes: shortened warm-up lengths 4/8/12/16
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin checks++; if ((got) !== (ex)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module standby_wakeup_control_tb;
   logic clk, nrst, halt_req, ei, di, fire, clear, ext0, srv;
   logic cpu_run, sys_en, osc_en, low_sel, busy, keep, in_en, accept, w_srv, w_res;
   logic [2:0] ei_op, mask;
   logic [7:0] tidle, ext_hi;
   logic [8:0] cpu_irq;
   logic [29:0] pidle, pirq, prun;
   logic [38:0][2:0] lvl;
   standby_pkg::standby_cfg_s cfg;
   standby_pkg::irq_pick_s fwd;
   int err_total, checks, n, bad;

   standby_wakeup_control #(.WARMUP_LEN_01(19'h4), .WARMUP_LEN_10(19'h8),
      .WARMUP_LEN_11(19'hc), .WARMUP_LEN_00(19'h10)) u_dut (.CLK(clk), .NRST(nrst),
      .HALT_REQ(halt_req), .EI_STROBE(ei), .EI_OPERAND(ei_op), .DI_STROBE(di),
      .STANDBY_CFG(cfg), .PERIPH_IDLE_EN(pidle), .TIMER_IDLE_EN(tidle),
      .CPU_IRQ(cpu_irq), .EXT_IRQ({ext_hi, ext0}), .PERIPH_IRQ(pirq),
      .MASKABLE_LEVEL(lvl), .CPU_RUN(cpu_run), .SYSCLK_EN(sys_en), .OSC_EN(osc_en),
      .LOW_CLK_SEL(low_sel), .WARMUP_BUSY(busy), .PERIPH_RUN(prun),
      .PIN_OUT_KEEP(keep), .PIN_IN_EN(in_en), .INTERRUPT_MASK_LEVEL(mask),
      .IRQ_FWD(fwd), .IRQ_ACCEPT(accept), .WAKE_SERVICE(w_srv), .WAKE_RESUME(w_res));

   ext_source_model u_src (.CLK(clk), .NRST(nrst), .fire(fire), .clear(clear),
      .service(w_srv), .line(ext0));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   task automatic mask_op(input logic e, input logic d, input logic [2:0] op);
      ei = e;
      di = d;
      ei_op = op;
      step();
      ei = 1'b0;
      di = 1'b0;
      // strobes drop for one edge so back-to-back calls never re-raise them in one step
      step();
   endtask

   task automatic halt(input logic [1:0] mode);
      cfg.halt_mode_select = mode;
      halt_req = 1'b1;
      step();
      halt_req = 1'b0;
      step();
   endtask

   // one-cycle pulse on the model's fire (0) or clear (1) input
   task automatic pulse_src(input logic sel_clear);
      fire = !sel_clear;
      clear = sel_clear;
      step();
      fire = 1'b0;
      clear = 1'b0;
   endtask

   // bounded wait for either wake pulse; srv tells which one
   task automatic wait_wake();
      n = 0;
      while (w_srv !== 1'b1 && w_res !== 1'b1)
      begin
         step();
         n++;
         if (n > 30000)
         begin
            err_total++;
            $display("CHECK FAILED wake exp 1 got 0");
            tally_and_finish();
         end
      end
      srv = w_srv;
   endtask

   task automatic t_reset();
      `CHK("cpu_run", 1'b1, cpu_run)
      `CHK("sys_en", 1'b1, sys_en)
      `CHK("prun", {30{1'b1}}, prun)
      `CHK("mask", 3'h7, mask)
   endtask

   task automatic t_mask();
      mask_op(1'b1, 1'b0, 3'h3);
      `CHK("mask ei", 3'h3, mask)
      mask_op(1'b1, 1'b0, 3'h5);
      `CHK("mask ei2", 3'h5, mask)
      mask_op(1'b0, 1'b1, 3'h0);
      `CHK("mask di", 3'h7, mask)
      mask_op(1'b1, 1'b0, 3'h2);
      mask_op(1'b1, 1'b1, 3'h1);
      `CHK("mask both", 3'h7, mask)
   endtask

   task automatic t_fwd();
      lvl[20] = 3'h2;
      lvl[25] = 3'h5;
      pirq[11] = 1'b1;
      pirq[16] = 1'b1;
      repeat (3) step();
      `CHK("fwd lvl", 3'h5, fwd.level)
      `CHK("fwd idx", 6'h22, fwd.index)
      `CHK("acc masked", 1'b0, accept)
      mask_op(1'b1, 1'b0, 3'h5);
      step();
      `CHK("acc equal", 1'b1, accept)
      mask_op(1'b1, 1'b0, 3'h6);
      step();
      `CHK("acc below", 1'b0, accept)
      cpu_irq[4] = 1'b1;
      repeat (3) step();
      `CHK("nmi lvl", 3'h7, fwd.level)
      `CHK("nmi idx", 6'h4, fwd.index)
      `CHK("nmi acc", 1'b1, accept)
      cpu_irq = '0;
      pirq = '0;
      mask_op(1'b0, 1'b1, 3'h0);
   endtask

   task automatic t_osc_idle(input logic [2:0] m, input logic exp_srv);
      mask_op(1'b1, 1'b0, m);
      halt(2'h2);
      `CHK("idle cpu", 1'b0, cpu_run)
      `CHK("idle sysclk", 1'b0, sys_en)
      `CHK("idle osc", 1'b1, osc_en)
      pulse_src(1'b0);
      wait_wake();
      `CHK("wake kind", exp_srv, srv)
      step();
      `CHK("run after", 1'b1, cpu_run)
      pulse_src(1'b1);
   endtask

   task automatic t_periph_idle();
      mask_op(1'b1, 1'b0, 3'h1);
      pidle = 30'h5;
      lvl[1] = 3'h4;
      halt(2'h3);
      `CHK("pidle cpu", 1'b0, cpu_run)
      `CHK("pidle run", 30'h5, prun)
      ext_hi[0] = 1'b1;
      repeat (6) step();
      `CHK("no timer en", 1'b0, cpu_run)
      tidle[0] = 1'b1;
      wait_wake();
      `CHK("pidle srv", 1'b1, srv)
      ext_hi = '0;
      tidle = '0;
      mask_op(1'b0, 1'b1, 3'h0);
   endtask

   task automatic t_stop(input logic [1:0] s, input logic low, input int lo, input int hi);
      // one clock mode is kept across full stop
      cfg.warmup_select = s;
      cfg.resume_low_osc = low;
      cfg.stop_drive = s[0];
      halt(2'h1);
      `CHK("stop osc", 1'b0, osc_en)
      `CHK("stop keep", s[0], keep)
      if (!s[0])
         `CHK("stop in", 1'b0, in_en)
      pulse_src(1'b0);
      n = 0;
      while (busy !== 1'b1 && n < 10)
      begin
         step();
         n++;
      end
      n = 0;
      bad = 0;
      while (busy === 1'b1 && n < 40000)
      begin
         if (sys_en !== 1'b0)
            bad++;
         n++;
         step();
      end
      `CHK("warm sysclk", 0, bad)
      `CHK("warm len", 1'b1, n >= lo && n <= hi)
      `CHK("low sel", low, low_sel)
      wait_wake();
      `CHK("stop resume", 1'b0, srv)
      pulse_src(1'b1);
      // the cleared line needs two edges through the synchroniser before the next halt
      repeat (2) step();
   endtask

   task automatic t_reset_release();
      halt(2'h1);
      nrst = 1'b0;
      #5;
      `CHK("rst cpu", 1'b1, cpu_run)
      `CHK("rst osc", 1'b1, osc_en)
      step();
      nrst = 1'b1;
      step();
      `CHK("rst mask", 3'h7, mask)
   endtask

   initial
   begin
      {nrst, halt_req, ei, di, fire, clear, ei_op} = '0;
      {tidle, ext_hi, cpu_irq, pidle, pirq, lvl} = '0;
      cfg = '0;
      err_total = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      #1;
      nrst = 1'b1;
      step();
      t_reset();
      t_mask();
      t_fwd();
      lvl[0] = 3'h3;
      t_osc_idle(3'h7, 1'b0);
      t_osc_idle(3'h2, 1'b1);
      t_periph_idle();
      t_stop(2'h1, 1'b0, 4, 4);
      t_stop(2'h2, 1'b0, 8, 8);
      t_stop(2'h3, 1'b0, 12, 12);
      t_stop(2'h0, 1'b0, 16, 16);
      // the tick divider restarts with warm-up, so the length is exact
      t_stop(2'h1, 1'b1, 4 * standby_pkg::LOW_OSC_DIV, 4 * standby_pkg::LOW_OSC_DIV);
      t_reset_release();
      tally_and_finish();
   end
endmodule
